// ==== mmpb_consts.svh ====
// Purpose: Constants for the physical bypass address path
// Assumes: 8-bit address space identifiers, 32-bit virtual addresses
// Notes:   Included by the package and the design modules
`ifndef MMPB_CONSTS_SVH
`define MMPB_CONSTS_SVH

// Field widths
`define MMPB_SID_W        8
`define MMPB_VA_W         32
`define MMPB_PA_W         36
`define MMPB_PA_HI_LSB    32
`define MMPB_PA_HI_MSB    35
`define MMPB_SID_LOW_MSB  3

// Identifier ranges and codes
`define MMPB_BYP_SID_LO   8'h20
`define MMPB_BYP_SID_HI   8'h2f
`define MMPB_ICFLUSH_SID  8'h36
`define MMPB_DCFLUSH_SID  8'h37

// Reset values
`define MMPB_PA_RST       36'h0_0000_0000

`endif

// ==== mmpb_pkg.sv ====
// Purpose: Types for the physical bypass address path
// Assumes: Constants come from mmpb_consts.svh
// Notes:   States, access classes and the physical address type
`default_nettype none
`include "mmpb_consts.svh"

package mmpb_pkg;

    // Access class from the identifier
    typedef enum logic [1:0] {
        MMPB_KIND_NORMAL,
        MMPB_KIND_BYPASS,
        MMPB_KIND_ICFLUSH,
        MMPB_KIND_DCFLUSH
    } mmpb_kind_e;

    // Sequencer states
    typedef enum logic [1:0] {
        MMPB_ST_IDLE,
        MMPB_ST_XLAT,
        MMPB_ST_OUT
    } mmpb_state_e;

    typedef logic [`MMPB_PA_W-1:0] mmpb_pa_t;

endpackage : mmpb_pkg

`default_nettype wire

// ==== mmpb_asi_decode.sv ====
// Purpose: Classify an address space identifier
// Assumes: Purely combinational, no clock
// Notes:   Flash invalidate codes are honoured only when enabled
`include "mmpb_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module mmpb_asi_decode
    import mmpb_pkg::*;
#(
    parameter bit FLUSH_SID_EN = 1'b1
)
(
    // Identifier in
    input  wire logic [`MMPB_SID_W-1:0] address_space_id,
    // Class out
    output mmpb_kind_e                  kind
);

    // Range check first, then optional flush codes
    always_comb
    begin
        kind = MMPB_KIND_NORMAL;
        if ((address_space_id >= `MMPB_BYP_SID_LO) && (address_space_id <= `MMPB_BYP_SID_HI))
        begin
            kind = MMPB_KIND_BYPASS;
        end
        else if (FLUSH_SID_EN && (address_space_id == `MMPB_ICFLUSH_SID))
        begin
            kind = MMPB_KIND_ICFLUSH;
        end
        else if (FLUSH_SID_EN && (address_space_id == `MMPB_DCFLUSH_SID))
        begin
            kind = MMPB_KIND_DCFLUSH;
        end
    end

endmodule : mmpb_asi_decode

`default_nettype wire

// ==== mmpb_bypass_path.sv ====
// Purpose: Address formation for alternate-space core accesses
// Assumes: One clock clk_sys at 25 MHz, synchronous active-low reset
// Notes:   One access in flight; normal accesses go out to the table walker
//
// Overview of operation
// - Identifiers 0x20 to 0x2f reach a physical address with no table lookup.
// - For a bypass access, address bits 35:32 come from identifier bits 3:0.
// - For a bypass access, address bits 31:0 are the virtual address unchanged.
// - A bypass access issues no referenced or modified write-back to the table.
// - Identifiers 0x36 and 0x37 may flash invalidate the instruction and data caches.
`include "mmpb_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module mmpb_bypass_path
    import mmpb_pkg::*;
#(
    parameter bit FLUSH_SID_EN = 1'b1
)
(
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    // Core request
    input  wire logic                   req_valid,
    output logic                        req_ready,
    input  wire logic [`MMPB_SID_W-1:0] address_space_id,
    input  wire logic [`MMPB_VA_W-1:0]  virt_addr_in,
    input  wire logic                   req_write,
    // Normal translation path
    output logic                        xlat_req_valid,
    output logic [`MMPB_VA_W-1:0]       xlat_virt_addr,
    output logic [`MMPB_SID_W-1:0]      xlat_space_id,
    input  wire logic                   xlat_done,
    input  wire logic [`MMPB_PA_W-1:0]  xlat_phys_addr,
    // Memory access out
    output logic                        mem_valid,
    input  wire logic                   mem_ready,
    output logic [`MMPB_PA_W-1:0]       phys_addr_out,
    output logic                        mem_write,
    output logic                        pte_wb_en,
    // Cache invalidate pulses
    output logic                        icache_flush,
    output logic                        dcache_flush
);

    mmpb_kind_e                  kind;
    mmpb_state_e                 state_q;
    mmpb_state_e                 state_d;
    mmpb_pa_t                    pa_q;
    mmpb_pa_t                    pa_d;
    logic [`MMPB_VA_W-1:0]       va_q;
    logic [`MMPB_VA_W-1:0]       va_d;
    logic [`MMPB_SID_W-1:0]      sid_q;
    logic [`MMPB_SID_W-1:0]      sid_d;
    logic                        wr_q;
    logic                        wr_d;
    logic                        wb_q;
    logic                        wb_d;
    logic                        icf_q;
    logic                        icf_d;
    logic                        dcf_q;
    logic                        dcf_d;
    logic                        accept;

    // Identifier classifier
    mmpb_asi_decode #(
        .FLUSH_SID_EN (FLUSH_SID_EN)
    ) u_decode (
        .address_space_id (address_space_id),
        .kind             (kind)
    );

    // Handshake outputs
    assign req_ready      = (state_q == MMPB_ST_IDLE);
    assign accept         = req_valid && req_ready;
    assign xlat_req_valid = (state_q == MMPB_ST_XLAT);
    assign mem_valid      = (state_q == MMPB_ST_OUT);

    // Registered data outputs
    assign xlat_virt_addr = va_q;
    assign xlat_space_id  = sid_q;
    assign phys_addr_out  = pa_q;
    assign mem_write      = wr_q;
    assign pte_wb_en      = wb_q && mem_valid;
    assign icache_flush   = icf_q;
    assign dcache_flush   = dcf_q;

    // Next-state and address formation
    always_comb
    begin
        state_d = state_q;
        pa_d    = pa_q;
        va_d    = va_q;
        sid_d   = sid_q;
        wr_d    = wr_q;
        wb_d    = wb_q;
        icf_d   = 1'b0;
        dcf_d   = 1'b0;
        unique case (state_q)
            MMPB_ST_IDLE:
            begin
                if (accept)
                begin
                    wr_d = req_write;
                    unique case (kind)
                        MMPB_KIND_BYPASS:
                        begin
                            pa_d[`MMPB_PA_HI_MSB:`MMPB_PA_HI_LSB] =
                                address_space_id[`MMPB_SID_LOW_MSB:0];
                            pa_d[`MMPB_VA_W-1:0] = virt_addr_in;
                            wb_d    = 1'b0;
                            state_d = MMPB_ST_OUT;
                        end
                        MMPB_KIND_ICFLUSH:
                        begin
                            icf_d = 1'b1;
                        end
                        MMPB_KIND_DCFLUSH:
                        begin
                            dcf_d = 1'b1;
                        end
                        MMPB_KIND_NORMAL:
                        begin
                            va_d    = virt_addr_in;
                            sid_d   = address_space_id;
                            state_d = MMPB_ST_XLAT;
                        end
                    endcase
                end
            end
            MMPB_ST_XLAT:
            begin
                if (xlat_done)
                begin
                    pa_d    = xlat_phys_addr;
                    wb_d    = 1'b1;
                    state_d = MMPB_ST_OUT;
                end
            end
            MMPB_ST_OUT:
            begin
                if (mem_ready)
                begin
                    state_d = MMPB_ST_IDLE;
                end
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            state_q <= MMPB_ST_IDLE;
            pa_q    <= `MMPB_PA_RST;
            va_q    <= '0;
            sid_q   <= '0;
            wr_q    <= 1'b0;
            wb_q    <= 1'b0;
            icf_q   <= 1'b0;
            dcf_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            pa_q    <= pa_d;
            va_q    <= va_d;
            sid_q   <= sid_d;
            wr_q    <= wr_d;
            wb_q    <= wb_d;
            icf_q   <= icf_d;
            dcf_q   <= dcf_d;
        end
    end

    // Checks on the formed address and side effects
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence s_byp_take;
        accept && (kind == MMPB_KIND_BYPASS);
    endsequence

    sequence s_norm_take;
        accept && (kind == MMPB_KIND_NORMAL);
    endsequence

    chk_bypass_direct: assert property (
        s_byp_take |=> mem_valid && !xlat_req_valid)
        else $error("bypass access did not go straight to memory");

    chk_pa_upper_bits: assert property (
        s_byp_take |=> phys_addr_out[35:32] == $past(address_space_id[3:0]))
        else $error("bypass upper address bits wrong");

    chk_pa_lower_bits: assert property (
        s_byp_take |=> phys_addr_out[31:0] == $past(virt_addr_in))
        else $error("bypass lower address bits wrong");

    chk_no_pte_wb: assert property (
        s_byp_take |=> (!pte_wb_en && mem_valid) until_with (mem_valid && mem_ready))
        else $error("table write-back during bypass access");

    // flush pulse only, no memory access
    chk_flush_pulse: assert property (
        accept && (kind inside {MMPB_KIND_ICFLUSH, MMPB_KIND_DCFLUSH}) |=>
            (icache_flush != dcache_flush) && !mem_valid
            ##1 ($past(accept) || (!icache_flush && !dcache_flush)))
        else $error("flash invalidate not a single pulse");

    chk_normal_walk: assert property (
        s_norm_take |=> xlat_req_valid && !mem_valid && xlat_virt_addr == $past(virt_addr_in))
        else $error("normal access skipped translation");

    chk_walk_result: assert property (
        xlat_req_valid && xlat_done |=> mem_valid && pte_wb_en
            && phys_addr_out == $past(xlat_phys_addr))
        else $error("walker address not forwarded");

endmodule : mmpb_bypass_path

`default_nettype wire

// ==== mmpb_far_model.sv ====
// Purpose: Far-side model of the table walker and the memory
// Assumes: Answers after wait_n cycles, changes just after the edge
// Notes:   Walker address is {4'h5, ~va} so it never equals the bypass address for the same va
`timescale 1ns/100ps
`default_nettype none

module mmpb_far_model
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // Requests from the path
    input  wire logic        xlat_req_valid,
    input  wire logic [31:0] xlat_virt_addr,
    input  wire logic        mem_valid,
    input  wire logic [3:0]  wait_n,
    // Answers
    output logic             xlat_done,
    output logic [35:0]      xlat_phys_addr,
    output logic             mem_ready
);
    logic [3:0] cnt_q;
    logic       tog_q;

    // Idle result bus toggles rather than holding the last value
    assign xlat_phys_addr = xlat_done ? {4'h5, ~xlat_virt_addr} : {36{tog_q}};

    // Answer once the wait runs out, drop after the taking edge
    always_ff @(posedge clk_sys)
    begin
        tog_q <= resetn ? ~tog_q : 1'b0;
        if (!resetn || !(xlat_req_valid || mem_valid) || xlat_done || mem_ready)
        begin
            cnt_q     <= 4'h0;
            xlat_done <= 1'b0;
            mem_ready <= 1'b0;
        end
        else if (cnt_q == wait_n)
        begin
            xlat_done <= xlat_req_valid;
            mem_ready <= mem_valid;
        end
        else
            cnt_q <= cnt_q + 4'h1;
    end
endmodule : mmpb_far_model
`default_nettype wire

// ==== mmpb_bypass_path_tb_top.sv ====
// Purpose: Self-checking bench for the bypass address path
// Assumes: Far model answers the walker and memory sides
// Notes:   Inputs change on the falling edge of clk_sys
`timescale 1ns/100ps
`default_nettype none

module mmpb_bypass_path_tb_top import mmpb_pkg::*;;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [7:0]  address_space_id = 8'h00;
    logic [31:0] virt_addr_in = 32'h0;
    logic [3:0]  wait_n = 4'h0;
    logic        req_ready, xlat_req_valid, xlat_done, mem_valid, mem_ready;
    logic        mem_write, pte_wb_en, icache_flush, dcache_flush;
    logic [31:0] xlat_virt_addr;
    logic [7:0]  xlat_space_id;
    logic [35:0] xlat_phys_addr, phys_addr_out;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cycles = 0;

    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;

    // Path under test and its far side
    mmpb_bypass_path i_dut (.clk_sys, .resetn, .req_valid, .req_ready, .address_space_id,
        .virt_addr_in, .req_write, .xlat_req_valid, .xlat_virt_addr, .xlat_space_id,
        .xlat_done, .xlat_phys_addr, .mem_valid, .mem_ready, .phys_addr_out, .mem_write,
        .pte_wb_en, .icache_flush, .dcache_flush);
    mmpb_far_model i_far (.clk_sys, .resetn, .xlat_req_valid, .xlat_virt_addr, .mem_valid,
        .wait_n, .xlat_done, .xlat_phys_addr, .mem_ready);

    task automatic conclude;
        $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One core access, judged from the identifier class
    task automatic access(input logic [7:0] id, input logic [31:0] va, input logic wr);
        logic byp;
        logic fl;
        byp = (id >= 8'h20) && (id <= 8'h2f);
        fl = (id == 8'h36) || (id == 8'h37);
        @(negedge clk_sys);
        req_valid = 1'b1;
        address_space_id = id;
        virt_addr_in = va;
        req_write = wr;
        while (req_ready !== 1'b1)
            @(negedge clk_sys);
        @(negedge clk_sys);
        req_valid = 1'b0;
        virt_addr_in = ~va;
        check("icache_flush", icache_flush, 36'(id == 8'h36));
        check("dcache_flush", dcache_flush, 36'(id == 8'h37));
        check("xlat_req_valid", xlat_req_valid, 36'(!(byp || fl)));
        if (fl)
        begin
            check("mem_valid", mem_valid, 36'h0);
            check("req_ready", req_ready, 36'h1);
        end
        else
        begin
            if (!byp)
            begin
                check("xlat_virt_addr", xlat_virt_addr, 36'(va));
                check("xlat_space_id", xlat_space_id, 36'(id));
            end
            while (mem_valid !== 1'b1)
                @(negedge clk_sys);
            check("phys_addr_out", phys_addr_out, byp ? {id[3:0], va} : {4'h5, ~va});
            check("pte_wb_en", pte_wb_en, 36'(!byp));
            check("mem_write", mem_write, 36'(wr));
            while (mem_ready !== 1'b1)
                @(negedge clk_sys);
            @(negedge clk_sys);
            check("req_ready", req_ready, 36'h1);
        end
    endtask : access

    // All sixteen bypass identifiers, prompt and slow memory
    task automatic bypass_sweep;
        for (int i = 0; i < 16; i++)
        begin
            wait_n = 4'(i % 3);
            access(8'h20 + 8'(i), {8{4'(i)}} ^ 32'ha5c3_0f96, i[0]);
        end
        $display("Test bypass_sweep done");
    endtask : bypass_sweep

    // Identifiers just outside and far from the bypass range
    task automatic normal_ids;
        logic [7:0] ids [7] = '{8'h1f, 8'h30, 8'h00, 8'h10, 8'hff, 8'h35, 8'h38};
        foreach (ids[i])
        begin
            wait_n = 4'(i * 2);
            access(ids[i], 32'h1357_9bdf + 32'(i), i[0]);
        end
        $display("Test normal_ids done");
    endtask : normal_ids

    // Flash invalidates one idle cycle apart, then a bypass one idle cycle after
    task automatic flush_ids;
        access(8'h36, 32'hffff_ffff, 1'b1);
        access(8'h37, 32'h0, 1'b1);
        access(8'h36, 32'h0, 1'b0);
        access(8'h2f, 32'hffff_ffff, 1'b1);
        $display("Test flush_ids done");
    endtask : flush_ids

    // Reset in the middle of a walk, then a bypass access to show recovery
    task automatic reset_mid;
        wait_n = 4'h9;
        @(negedge clk_sys);
        req_valid = 1'b1;
        address_space_id = 8'h05;
        virt_addr_in = 32'h2468_ace0;
        @(negedge clk_sys);
        req_valid = 1'b0;
        resetn = 1'b0;
        check("xlat_req_valid", xlat_req_valid, 36'h1);
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        check("req_ready", req_ready, 36'h1);
        check("xlat_req_valid", xlat_req_valid, 36'h0);
        check("mem_valid", mem_valid, 36'h0);
        check("pte_wb_en", pte_wb_en, 36'h0);
        check("phys_addr_out", phys_addr_out, 36'h0);
        access(8'h2c, 32'h1234_5678, 1'b0);
        $display("Test reset_mid done");
    endtask : reset_mid

    // Watchdog well above the expected run length
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            conclude();
        end
    end

    // Main sequence
    initial
    begin
        repeat (16) @(negedge clk_sys);
        resetn = 1'b1;
        bypass_sweep();
        normal_ids();
        flush_ids();
        reset_mid();
        conclude();
    end
endmodule : mmpb_bypass_path_tb_top
`default_nettype wire
